// ### include/ums_defs.svh
// Register offsets, field positions, reset values and counts of the modem status tracker.
`ifndef UMS_DEFS_SVH
`define UMS_DEFS_SVH

`define UMS_OFS_STATUS     4'h0
`define UMS_OFS_CONTROL    4'h4
`define UMS_OFS_INT_STATUS 4'h8
`define UMS_OFS_INT_MASK   4'hC

`define UMS_MCR_DTR        0
`define UMS_MCR_RTS        1
`define UMS_MCR_OUT_A      2
`define UMS_MCR_OUT_B      3
`define UMS_MCR_LOOP       4
`define UMS_MCR_AUTO_FLOW  5

`define UMS_MSR_CTS_DELTA  0
`define UMS_MSR_DSR_DELTA  1
`define UMS_MSR_RING_TRAIL 2
`define UMS_MSR_DCD_DELTA  3

`define UMS_CONTROL_RESET  8'h00
`define UMS_FLAGS_RESET    4'h0
`define UMS_MASK_RESET     4'h0
`define UMS_PIN_IDLE       4'hF
`define UMS_PRIME_CYCLES   2'h3

`endif

// ### include/ums_pkg.sv
// Types shared by the modem status tracker modules.
package ums_pkg;

    typedef logic [7:0] ums_byte_t;
    typedef logic [3:0] ums_nib_t;

    typedef enum logic [4:0] {
        UMS_SEL_NONE       = 5'h01,
        UMS_SEL_STATUS     = 5'h02,
        UMS_SEL_CONTROL    = 5'h04,
        UMS_SEL_INT_STATUS = 5'h08,
        UMS_SEL_INT_MASK   = 5'h10
    } ums_sel_t;

    typedef enum logic [1:0] {
        UMS_FLOW_RUN  = 2'h1,
        UMS_FLOW_HOLD = 2'h2
    } ums_flow_t;

endpackage : ums_pkg

// ### logic/ums_sync.sv
// Two-stage synchroniser for a group of asynchronous input pins.
`timescale 1ns/1ps
module ums_sync #(
    parameter int         WIDTH     = 4,
    parameter logic [3:0] RESET_VAL = 4'hF
) (
    // Clock and reset.
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Pins in and synchronised levels out.
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] level
);
    logic [WIDTH-1:0] stage;

    if (WIDTH < 1 || WIDTH > 4)
    begin : g_width_check
        $error("ums_sync width must be 1 to 4");
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stage <= RESET_VAL[WIDTH-1:0];
            level <= RESET_VAL[WIDTH-1:0];
        end
        else
        begin
            stage <= pin;
            level <= stage;
        end
    end
endmodule : ums_sync

// ### logic/ums_flow.sv
// Clear-to-send flow gate that pauses the transmitter only between characters.
`timescale 1ns/1ps
module ums_flow
    import ums_pkg::*;
(
    // Clock and reset.
    input  wire logic pclk,
    input  wire logic presetn,
    // Control and transmitter status.
    input  wire logic auto_flow,
    input  wire logic cts_active,
    input  wire logic tx_busy,
    // Permission to start the next character.
    output logic      tx_enable
);
    ums_flow_t state;
    ums_flow_t next_state;

    always_comb
    begin
        next_state = state;
        unique case (state)
            UMS_FLOW_RUN:
                if (auto_flow && !cts_active && !tx_busy)
                    next_state = UMS_FLOW_HOLD;
            UMS_FLOW_HOLD:
                if (!auto_flow || cts_active)
                    next_state = UMS_FLOW_RUN;
            default:
                next_state = UMS_FLOW_RUN;
        endcase
    end

    // A character under way always finishes before the hold takes effect.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state <= UMS_FLOW_RUN;
        else
            state <= next_state;
    end

    assign tx_enable = (state == UMS_FLOW_RUN);
endmodule : ums_flow

// ### logic/ums_tracker.sv
// Modem status tracker: modem pins, change flags, loopback, flow control and APB registers.
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "ums_defs.svh"
module ums_tracker #(
    parameter int ADDR_WIDTH = 4
) (
    // APB clock and reset.
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave.
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_WIDTH-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Modem input pins, active low.
    input  wire logic                  dcd_n,
    input  wire logic                  ri_n,
    input  wire logic                  dsr_n,
    input  wire logic                  cts_n,
    // Modem output pins, active low.
    output logic                       dtr_n,
    output logic                       rts_n,
    output logic                       user_output_a_n,
    output logic                       user_output_b_n,
    // Transmitter handshake.
    input  wire logic                  tx_busy,
    output logic                       tx_enable,
    // Interrupts.
    output logic                       modem_irq_req,
    output logic                       irq
);
    import ums_pkg::*;

    if (ADDR_WIDTH < 4 || ADDR_WIDTH > 16)
    begin : g_addr_check
        $error("ums_tracker address width must be 4 to 16");
    end

    function automatic ums_sel_t decode(input logic [ADDR_WIDTH-1:0] addr);
        ums_sel_t sel;
        sel = UMS_SEL_NONE;
        if ((addr >> 4) == '0)
        begin
            unique case (addr[3:0])
                `UMS_OFS_STATUS:     sel = UMS_SEL_STATUS;
                `UMS_OFS_CONTROL:    sel = UMS_SEL_CONTROL;
                `UMS_OFS_INT_STATUS: sel = UMS_SEL_INT_STATUS;
                `UMS_OFS_INT_MASK:   sel = UMS_SEL_INT_MASK;
                default:             sel = UMS_SEL_NONE;
            endcase
        end
        return sel;
    endfunction : decode

    ums_byte_t modem_control;
    ums_nib_t  flags;
    ums_nib_t  int_status;
    ums_nib_t  int_mask;
    ums_nib_t  pin_level_n;
    ums_nib_t  cur;
    ums_nib_t  prev;
    ums_nib_t  set_flags;
    ums_nib_t  rd_flags;
    ums_nib_t  rd_int;
    logic [1:0] prime_cnt;
    logic       primed;
    logic       loop;
    logic       setup;
    logic       access;
    ums_sel_t   sel;

    // Pins come from another domain and pass two flops first.
    ums_sync #(
        .WIDTH     (4),
        .RESET_VAL (`UMS_PIN_IDLE)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     ({dcd_n, ri_n, dsr_n, cts_n}),
        .level   (pin_level_n)
    );

    assign loop   = modem_control[`UMS_MCR_LOOP];
    assign setup  = psel && !penable;
    assign access = psel && penable;
    assign sel    = decode(paddr);
    assign pready = 1'b1;

    // Current active-high modem levels, from pins or looped back.
    always_comb
    begin
        if (loop)
        begin
            cur[3] = modem_control[`UMS_MCR_OUT_B];
            cur[2] = modem_control[`UMS_MCR_OUT_A];
            cur[1] = modem_control[`UMS_MCR_DTR];
            cur[0] = modem_control[`UMS_MCR_RTS];
        end
        else
        begin
            cur = ~pin_level_n;
        end
    end

    // Edge detection waits until the synchroniser holds real pin levels.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prime_cnt <= 2'h0;
        else if (prime_cnt != `UMS_PRIME_CYCLES)
            prime_cnt <= prime_cnt + 2'h1;
    end

    assign primed = (prime_cnt == `UMS_PRIME_CYCLES);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prev <= 4'h0;
        else
            prev <= cur;
    end

    // Same edge rules apply whether levels come from pins or loopback.
    always_comb
    begin
        set_flags = 4'h0;
        if (primed)
        begin
            set_flags[`UMS_MSR_DCD_DELTA]  = cur[3] ^ prev[3];
            set_flags[`UMS_MSR_RING_TRAIL] = prev[2] && !cur[2];
            set_flags[`UMS_MSR_DSR_DELTA]  = cur[1] ^ prev[1];
            set_flags[`UMS_MSR_CTS_DELTA]  = cur[0] ^ prev[0];
        end
    end

    // Only flags that the read returned are cleared; a new set wins.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flags <= `UMS_FLAGS_RESET;
        else if (access && !pwrite && sel == UMS_SEL_STATUS)
            flags <= (flags & ~rd_flags) | set_flags;
        else
            flags <= flags | set_flags;
    end

    assign modem_irq_req = |flags;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            int_status <= 4'h0;
        else if (access && !pwrite && sel == UMS_SEL_INT_STATUS)
            int_status <= (int_status & ~rd_int) | set_flags;
        else
            int_status <= int_status | set_flags;
    end

    assign irq = |(int_status & int_mask);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            modem_control <= `UMS_CONTROL_RESET;
            int_mask      <= `UMS_MASK_RESET;
        end
        else if (access && pwrite)
        begin
            if (sel == UMS_SEL_CONTROL)
                modem_control <= {2'h0, pwdata[5:0]};
            if (sel == UMS_SEL_INT_MASK)
                int_mask <= pwdata[3:0];
        end
    end

    // Read data is captured in the setup cycle and held through access.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata   <= 32'h0;
            rd_flags <= 4'h0;
            rd_int   <= 4'h0;
        end
        else if (setup && !pwrite)
        begin
            rd_flags <= 4'h0;
            rd_int   <= 4'h0;
            unique case (sel)
                UMS_SEL_STATUS:
                begin
                    prdata   <= {24'h0, cur, flags};
                    rd_flags <= flags;
                end
                UMS_SEL_CONTROL:
                    prdata <= {24'h0, modem_control};
                UMS_SEL_INT_STATUS:
                begin
                    prdata <= {28'h0, int_status};
                    rd_int <= int_status;
                end
                UMS_SEL_INT_MASK:
                    prdata <= {28'h0, int_mask};
                UMS_SEL_NONE:
                    prdata <= 32'h0;
            endcase
        end
    end

    assign pslverr = access && (sel == UMS_SEL_NONE);

    // In loopback the output pins stay inactive.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dtr_n           <= 1'b1;
            rts_n           <= 1'b1;
            user_output_a_n <= 1'b1;
            user_output_b_n <= 1'b1;
        end
        else
        begin
            dtr_n           <= loop || !modem_control[`UMS_MCR_DTR];
            rts_n           <= loop || !modem_control[`UMS_MCR_RTS];
            user_output_a_n <= loop || !modem_control[`UMS_MCR_OUT_A];
            user_output_b_n <= loop || !modem_control[`UMS_MCR_OUT_B];
        end
    end

    ums_flow u_flow (
        .pclk       (pclk),
        .presetn    (presetn),
        .auto_flow  (modem_control[`UMS_MCR_AUTO_FLOW]),
        .cts_active (cur[0]),
        .tx_busy    (tx_busy),
        .tx_enable  (tx_enable)
    );

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_dcd_change_flag: assert property (
        primed && (cur[3] != prev[3]) |=> flags[`UMS_MSR_DCD_DELTA])
        else $error("carrier change did not set its flag");

    chk_status_read_clear: assert property (
        setup && !pwrite && sel == UMS_SEL_STATUS && set_flags == 4'h0
        ##1 access && set_flags == 4'h0
        |=> flags == 4'h0)
        else $error("status read did not clear change flags");

    chk_dcd_status_bit: assert property (
        setup && !pwrite && sel == UMS_SEL_STATUS |=> prdata[7] == ($past(loop) ?
        $past(modem_control[`UMS_MCR_OUT_B]) : !$past(pin_level_n[3])))
        else $error("carrier status bit wrong");

    chk_ring_status_bit: assert property (
        setup && !pwrite && sel == UMS_SEL_STATUS |=> prdata[6] == ($past(loop) ?
        $past(modem_control[`UMS_MCR_OUT_A]) : !$past(pin_level_n[2])))
        else $error("ring status bit wrong");

    chk_dsr_status_bit: assert property (
        setup && !pwrite && sel == UMS_SEL_STATUS |=> prdata[5] == ($past(loop) ?
        $past(modem_control[`UMS_MCR_DTR]) : !$past(pin_level_n[1])))
        else $error("data set ready status bit wrong");

    chk_cts_status_bit: assert property (
        setup && !pwrite && sel == UMS_SEL_STATUS |=> prdata[4] == ($past(loop) ?
        $past(modem_control[`UMS_MCR_RTS]) : !$past(pin_level_n[0])))
        else $error("clear to send status bit wrong");

    chk_flow_off_runs: assert property (
        !modem_control[`UMS_MCR_AUTO_FLOW] |=> tx_enable)
        else $error("transmit held while flow control is off");

    chk_flow_stop_idle: assert property (
        modem_control[`UMS_MCR_AUTO_FLOW] && !cur[0] && !tx_busy
        ##1 modem_control[`UMS_MCR_AUTO_FLOW] && !cur[0] |-> !tx_enable)
        else $error("transmit not paused between characters");

    chk_flow_busy_hold: assert property (
        tx_enable && tx_busy |=> tx_enable)
        else $error("transmit paused during a character");

    chk_dsr_cts_change: assert property (
        primed && (cur[1:0] != prev[1:0]) |=> |flags[1:0])
        else $error("dsr or cts change lost");

    chk_ring_trailing: assert property (
        !flags[`UMS_MSR_RING_TRAIL] && !(primed && prev[2] && !cur[2])
        |=> !flags[`UMS_MSR_RING_TRAIL])
        else $error("ring flag set without a rising ring pin");

    chk_irq_pending: assert property (
        (flags != 4'h0) |-> modem_irq_req)
        else $error("modem interrupt request missing");

    chk_reset_flags: assert property (
        !primed |-> flags == 4'h0)
        else $error("change flags set before inputs settled");

    chk_loop_edge: assert property (
        primed && loop && $past(loop)
        && modem_control[`UMS_MCR_RTS] != $past(modem_control[`UMS_MCR_RTS])
        |=> flags[`UMS_MSR_CTS_DELTA])
        else $error("looped clear to send change lost");

endmodule : ums_tracker

// ### sim/ums_modem_model.sv
// Behavioural modem that drives the four active-low status lines.
`timescale 1ns/1ps
module ums_modem_model (
    // Clock and reset.
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Requested line levels and response speed.
    input  wire logic [3:0] want,
    input  wire logic       slow,
    // Modem lines, active low.
    output logic            dcd_n,
    output logic            ri_n,
    output logic            dsr_n,
    output logic            cts_n
);
    logic [3:0] lag;

    // A slow modem shows each new level one cycle later.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lag                   <= 4'hF;
            {dcd_n, ri_n, dsr_n}  <= 3'h7;
            cts_n                 <= 1'h1;
        end
        else
        begin
            lag                   <= want;
            {dcd_n, ri_n, dsr_n}  <= slow ? lag[3:1] : want[3:1];
            cts_n                 <= slow ? lag[0] : want[0];
        end
    end
endmodule : ums_modem_model

// ### sim/ums_tracker_tb_top.sv
// Self-checking testbench of the modem status tracker.
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); end end
module ums_tracker_tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [4:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  want, cur, lp, flags, ints, m, c;
    logic        slow, tx_busy, tx_enable, irq, mirq;
    logic        dcd_n, ri_n, dsr_n, cts_n, dtr_n, rts_n, oa_n, ob_n;
    int          fail_count, compares, cycles, seed, i;

    ums_modem_model modem (.pclk(pclk), .presetn(presetn), .want(want), .slow(slow),
        .dcd_n(dcd_n), .ri_n(ri_n), .dsr_n(dsr_n), .cts_n(cts_n));

    ums_tracker #(.ADDR_WIDTH(5)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dcd_n(dcd_n), .ri_n(ri_n), .dsr_n(dsr_n), .cts_n(cts_n), .dtr_n(dtr_n),
        .rts_n(rts_n), .user_output_a_n(oa_n), .user_output_b_n(ob_n), .tx_busy(tx_busy),
        .tx_enable(tx_enable), .modem_irq_req(mirq), .irq(irq));

    // Flags raised by a move of the lines, ordered carrier, ring, data set ready, clear to send.
    function automatic logic [3:0] fl(input logic [3:0] o, input logic [3:0] n);
        fl = {o[3] ^ n[3], ~o[2] & n[2], o[1] ^ n[1], o[0] ^ n[0]};
    endfunction : fl

    task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do
            @(posedge pclk);
        while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic tally_and_finish;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        pclk = 1'h0;
        forever #2 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            tally_and_finish;
        end
    end

    initial
    begin
        seed = 40;
        {presetn, psel, penable, pwrite, slow, tx_busy} = 6'h00;
        paddr = 5'h00;
        pwdata = 32'h0;
        want = 4'hF;
        cur = 4'hF;
        flags = 4'h0;
        ints = 4'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        repeat (4) @(posedge pclk);
        apb(1'h0, 5'h00, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'h0, 5'h04, 32'h0);
        `CHK(rd, 32'h0)
        `CHK({dtr_n, rts_n, oa_n, ob_n, mirq, irq}, 6'h3C)
        apb(1'h1, 5'h10, 32'hFF);
        `CHK(err, 1'h1)
        apb(1'h0, 5'h10, 32'h0);
        `CHK({err, rd}, 33'h100000000)
        for (i = 0; i < 30; i++)
        begin
            @(posedge pclk);
            want <= (i < 2) ? ((i == 0) ? 4'hB : 4'hF) : 4'($random(seed));
            slow <= 1'($random(seed));
            m = 4'($random(seed));
            c = 4'($random(seed));
            apb(1'h1, 5'h0C, {28'h0, m});
            apb(1'h1, 5'h04, {28'h0, c});
            repeat (6) @(posedge pclk);
            flags |= fl(cur, want);
            ints |= fl(cur, want);
            cur = want;
            `CHK({ob_n, oa_n, rts_n, dtr_n}, ~c)
            `CHK(mirq, |flags)
            `CHK(irq, |(ints & m))
            if (i[0])
            begin
                apb(1'h0, 5'h00, 32'h0);
                `CHK(rd, {24'h0, ~cur, flags})
                flags = 4'h0;
            end
            else
            begin
                apb(1'h0, 5'h08, 32'h0);
                `CHK(rd, {28'h0, ints})
                ints = 4'h0;
            end
        end
        apb(1'h0, 5'h0C, 32'h0);
        `CHK(rd, {28'h0, m})
        apb(1'h0, 5'h04, 32'h0);
        `CHK(rd, {28'h0, c})
        apb(1'h0, 5'h00, 32'h0);
        `CHK(rd, {24'h0, ~cur, flags})
        apb(1'h1, 5'h04, 32'h1F);
        lp = 4'h0;
        repeat (6) @(posedge pclk);
        apb(1'h0, 5'h00, 32'h0);
        `CHK(rd[7:4], 4'hF)
        `CHK({dtr_n, rts_n, oa_n, ob_n}, 4'hF)
        apb(1'h0, 5'h08, 32'h0);
        for (i = 0; i < 12; i++)
        begin
            c = 4'($random(seed));
            apb(1'h1, 5'h04, {27'h0, 1'h1, c});
            repeat (6) @(posedge pclk);
            flags = fl(lp, ~{c[3], c[2], c[0], c[1]});
            lp = ~{c[3], c[2], c[0], c[1]};
            `CHK(mirq, |flags)
            apb(1'h0, 5'h00, 32'h0);
            `CHK(rd, {24'h0, c[3], c[2], c[0], c[1], flags})
        end
        apb(1'h1, 5'h04, 32'h20);
        @(posedge pclk);
        want <= cur & 4'hE;
        repeat (6) @(posedge pclk);
        `CHK(tx_enable, 1'h1)
        tx_busy <= 1'h1;
        want <= cur | 4'h1;
        repeat (6) @(posedge pclk);
        `CHK(tx_enable, 1'h1)
        tx_busy <= 1'h0;
        repeat (3) @(posedge pclk);
        `CHK(tx_enable, 1'h0)
        apb(1'h1, 5'h04, 32'h0);
        repeat (3) @(posedge pclk);
        `CHK(tx_enable, 1'h1)
        tally_and_finish;
    end
endmodule : ums_tracker_tb_top
